// [icr_io_control_register_bank.sv]
// i/o control register bank: mode, port control, prescaler and interrupt logic
`timescale 1ns/1ps
// =========================================================================
// Summary of operation
// - prescale select doubles divide ratio per step
// - mode bit 3 gives prescaler to watchdog
// - mode bit 4 picks external count edge
// - mode bit 5 picks external timer source
// - mode bit 6 shows global interrupt enable
// - mode bit 7 picks external interrupt edge
// - first watchdog interrupt after half period when prescaler on watchdog
// - direction bit zero output, one input
// - change enable bit n arms pin n
// - prescaler view reads live prescaler count
// - pull-down active low, nibbles swapped
// - open-drain per pin, bit 3 plain
// - pull-high active low, bit 3 plain
// - constant sink on pin 1 when output
// - system bit 3 enables low-power reset
// - system bit 5 enables low-voltage reset
// - system bit 6 makes pin 0 interrupt
// - system bit 7 enables watchdog
// - mask bits 0-2 enable three interrupts
// - mask bit 6 gated by configuration
// - access only via i/o-control instructions
// - external interrupt disables pin 0 change
// - flags sticky until software clears
// =========================================================================
module icr_io_control_register_bank (
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  io_ctrl_write_instr_in,
   input  wire logic                  io_ctrl_read_instr_in,
   input  wire logic [7:0]            io_addr_in,
   input  wire logic [7:0]            io_wdata_in,
   input  wire logic                  mode_write_in,
   input  wire logic                  disable_int_instr_in,
   input  wire logic                  hw_int_entry_in,
   input  wire logic                  enable_int_instr_in,
   input  wire logic                  return_enable_instr_in,
   input  wire logic                  watchdog_clear_instr_in,
   input  wire logic                  watchdog_tick_in,
   input  wire logic                  cfg_wdt_int_enable_in,
   input  wire logic                  ext_timer_input_in,
   input  wire logic [7:0]            port_pins_in,
   input  wire logic                  timer_overflow_in,
   input  wire logic [7:0]            flag_clear_in,
   output logic [7:0]                 io_rdata_out,
   output logic                       io_rvalid_out,
   output logic [7:0]                 timer_watchdog_mode_out,
   output logic                       main_timer_tick_out,
   output logic                       watchdog_reset_out,
   output logic [7:0]                 int_flags_out,
   output logic                       int_request_out,
   output icr_pkg::icr_pin_ctl_t      pin_ctl_out,
   output icr_pkg::icr_sys_ctl_t      sys_ctl_out
);
   import icr_pkg::*;

   // =====================================================================
   // state
   typedef struct packed {
      logic [7:0]   mode;
      logic [7:0]   dir;
      logic [7:0]   pce;
      logic [7:0]   pd;
      logic [7:0]   od;
      logic [7:0]   ph;
      logic [7:0]   sys;
      logic [7:0]   imask;
      logic [7:0]   presc;
      logic [7:0]   flags;
      logic [7:0]   rdata;
      logic         rvalid;
      logic [7:0]   pin_prev;
      logic         tin_prev;
      logic         timer_tick;
      logic         wdt_reset;
      logic         irq;
      icr_pin_ctl_t pins;
      icr_sys_ctl_t sctl;
   } icr_state_t;

   icr_state_t st;
   icr_state_t next_st;

   // low n bits set, n from 0 to 8
   function automatic logic [7:0] icr_low_mask(input logic [3:0] n);
      logic [8:0] t;
      t = (9'h001 << n) - 9'h001;
      return t[7:0];
   endfunction

   // =====================================================================
   // next-state logic
   always_comb begin
      logic       timer_evt;
      logic       presc_evt;
      logic       wdt_evt;
      logic       wdt_int_evt;
      logic [2:0] ps;
      logic [3:0] ps_w;
      logic [7:0] cnt;
      logic [7:0] chg;
      logic       ext_evt;
      logic [7:0] set;
      logic [7:0] eff_mask;
      timer_evt   = 1'b0;
      presc_evt   = 1'b0;
      wdt_evt     = 1'b0;
      wdt_int_evt = 1'b0;
      ps          = st.mode[ICR_MODE_PS_LSB +: 3];
      ps_w        = {1'b0, ps};
      cnt         = st.presc;
      chg         = 8'h00;
      ext_evt     = 1'b0;
      set         = 8'h00;
      eff_mask    = 8'h00;
      next_st     = st;

      // register writes through the i/o-control write instruction
      // instruction-only access
      if (io_ctrl_write_instr_in) begin
         case (io_addr_in)
            ICR_ADDR_PORT_DIRECTION:     next_st.dir = io_wdata_in;
            ICR_ADDR_PIN_CHANGE_ENABLE:  next_st.pce = io_wdata_in;
            ICR_ADDR_PULL_DOWN_CONTROL:  next_st.pd = io_wdata_in;
            ICR_ADDR_OPEN_DRAIN_CONTROL: next_st.od = io_wdata_in;
            ICR_ADDR_PULL_HIGH_CONTROL:  next_st.ph = io_wdata_in;
            ICR_ADDR_SYSTEM_CONTROL:     next_st.sys = io_wdata_in & ICR_SYSCTL_WMASK;
            ICR_ADDR_INTERRUPT_MASK:     next_st.imask = io_wdata_in & ICR_IMASK_WMASK;
            default:                     next_st.sys = next_st.sys;
         endcase
      end

      // mode register: bit 6 is not writable, it follows the core
      if (mode_write_in) begin
         next_st.mode = {io_wdata_in[7], st.mode[ICR_MODE_GIE], io_wdata_in[5:0]};
      end

      // global enable tracking, masking wins a tie
      if (disable_int_instr_in || hw_int_entry_in) begin
         next_st.mode[ICR_MODE_GIE] = 1'b0;
      end else if (enable_int_instr_in || return_enable_instr_in) begin
         next_st.mode[ICR_MODE_GIE] = 1'b1;
      end

      if (st.mode[ICR_MODE_SOURCE]) begin
         timer_evt = st.mode[ICR_MODE_EDGE] ? (st.tin_prev && !ext_timer_input_in)
                                            : (!st.tin_prev && ext_timer_input_in);
      end else begin
         timer_evt = 1'b1;
      end
      next_st.tin_prev = ext_timer_input_in;

      wdt_evt = watchdog_tick_in && st.sys[ICR_SYS_WDT_EN];

      presc_evt = st.mode[ICR_MODE_ASSIGN] ? wdt_evt : timer_evt;
      if (presc_evt) begin
         cnt = st.presc + 8'h01;
      end

      // ratios are powers of two from the field
      next_st.timer_tick = 1'b0;
      next_st.wdt_reset  = 1'b0;
      if (st.mode[ICR_MODE_ASSIGN]) begin
         next_st.timer_tick = timer_evt;
         next_st.wdt_reset  = wdt_evt && ((cnt & icr_low_mask(ps_w)) == 8'h00);
         // interrupt at half period, then every full one
         wdt_int_evt = wdt_evt
                       && ((cnt & icr_low_mask(ps_w + 4'h1)) == (8'h01 << ps));
      end else begin
         next_st.timer_tick = timer_evt && ((cnt & icr_low_mask(ps_w + 4'h1)) == 8'h00);
         next_st.wdt_reset  = wdt_evt;
         wdt_int_evt        = wdt_evt;
      end

      // a watchdog clear restarts the count so the half period is exact
      if (watchdog_clear_instr_in && st.mode[ICR_MODE_ASSIGN]) begin
         cnt = 8'h00;
      end
      // moving the prescaler restarts it, so no stale ratio carries over
      if (mode_write_in && (io_wdata_in[ICR_MODE_ASSIGN] != st.mode[ICR_MODE_ASSIGN])) begin
         cnt = 8'h00;
      end
      next_st.presc = cnt;

      // pin 0 change ignored while it is the interrupt pin
      chg = (port_pins_in ^ st.pin_prev) & st.pce
            & ~{7'h00, st.sys[ICR_SYS_EXT_SEL]};
      next_st.pin_prev = port_pins_in;

      if (st.sys[ICR_SYS_EXT_SEL]) begin
         ext_evt = st.mode[ICR_MODE_EXT_INT_EDGE] ? (!st.pin_prev[0] && port_pins_in[0])
                                                  : (st.pin_prev[0] && !port_pins_in[0]);
      end

      // sticky flags, a new event beats a clear
      set[ICR_INT_TIMER]  = timer_overflow_in;
      set[ICR_INT_CHANGE] = |chg;
      set[ICR_INT_EXT]    = ext_evt;
      set[ICR_INT_WDT]    = wdt_int_evt;
      next_st.flags = ((st.flags & ~flag_clear_in) | set) & ICR_IMASK_WMASK;

      eff_mask = st.imask;
      eff_mask[ICR_INT_WDT] = st.imask[ICR_INT_WDT] && cfg_wdt_int_enable_in;
      next_st.irq = st.mode[ICR_MODE_GIE] && (|(st.flags & eff_mask));

      // read path: one cycle after the read instruction
      next_st.rvalid = io_ctrl_read_instr_in;
      next_st.rdata  = 8'h00;
      if (io_ctrl_read_instr_in) begin
         case (io_addr_in)
            ICR_ADDR_PORT_DIRECTION:     next_st.rdata = st.dir;
            ICR_ADDR_PIN_CHANGE_ENABLE:  next_st.rdata = st.pce;
            ICR_ADDR_PRESCALER_VIEW:     next_st.rdata = st.presc;
            ICR_ADDR_PULL_DOWN_CONTROL:  next_st.rdata = st.pd;
            ICR_ADDR_OPEN_DRAIN_CONTROL: next_st.rdata = st.od;
            ICR_ADDR_PULL_HIGH_CONTROL:  next_st.rdata = st.ph;
            ICR_ADDR_SYSTEM_CONTROL:     next_st.rdata = st.sys;
            ICR_ADDR_INTERRUPT_MASK:     next_st.rdata = st.imask;
            default:                     next_st.rdata = 8'h00;
         endcase
      end

      // pin controls, registered so the pads see clean levels
      // output enable low in output mode
      next_st.pins.oe_n = st.dir;
      next_st.pins.pull_down_n = {st.pd[3:0], st.pd[7:4]};
      next_st.pins.open_drain = st.od & ~(8'h01 << ICR_PLAIN_PIN);
      next_st.pins.pull_high_n = st.ph | (8'h01 << ICR_PLAIN_PIN);
      // sink only while pin 1 drives
      next_st.pins.const_sink = st.sys[ICR_SYS_CONST_SINK] && !st.dir[1];
      next_st.sctl.low_power_reset_enable = st.sys[ICR_SYS_LOW_POWER];
      next_st.sctl.low_voltage_reset_enable = st.sys[ICR_SYS_LOW_VOLT];
      next_st.sctl.watchdog_enable = st.sys[ICR_SYS_WDT_EN];
      next_st.sctl.ext_int_select = st.sys[ICR_SYS_EXT_SEL];
   end

   // =====================================================================
   // state register, synchronous reset
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         st.mode       <= ICR_RST_MODE;
         st.dir        <= ICR_RST_DIRECTION;
         st.pce        <= ICR_RST_PCE;
         st.pd         <= ICR_RST_PULL_DOWN;
         st.od         <= ICR_RST_OPEN_DRAIN;
         st.ph         <= ICR_RST_PULL_HIGH;
         st.sys        <= ICR_RST_SYSCTL;
         st.imask      <= ICR_RST_IMASK;
         st.presc      <= ICR_RST_PRESCALER;
         st.flags      <= 8'h00;
         st.rdata      <= 8'h00;
         st.rvalid     <= 1'b0;
         st.pin_prev   <= 8'h00;
         st.tin_prev   <= 1'b0;
         st.timer_tick <= 1'b0;
         st.wdt_reset  <= 1'b0;
         st.irq        <= 1'b0;
         st.pins       <= '{oe_n: 8'hff, pull_down_n: 8'hff, open_drain: 8'h00,
                            pull_high_n: 8'hff, const_sink: 1'b0};
         st.sctl       <= '{low_power_reset_enable: 1'b0, low_voltage_reset_enable: 1'b1,
                            watchdog_enable: 1'b1, ext_int_select: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state flops
   assign io_rdata_out            = st.rdata;
   assign io_rvalid_out           = st.rvalid;
   assign timer_watchdog_mode_out = st.mode;
   assign main_timer_tick_out     = st.timer_tick;
   assign watchdog_reset_out      = st.wdt_reset;
   assign int_flags_out           = st.flags;
   assign int_request_out         = st.irq;
   assign pin_ctl_out             = st.pins;
   assign sys_ctl_out             = st.sctl;

   // =====================================================================
   // checks
   AST_UNUSED_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (st.sys & ~ICR_SYSCTL_WMASK) == 8'h00 && (st.imask & ~ICR_IMASK_WMASK) == 8'h00)
      else $error("unused control bits not zero");

   AST_OD_PIN3: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 (pin_ctl_out.open_drain == ($past(st.od) & 8'hf7)))
      else $error("open-drain output mismatch");

   AST_PH_PIN3: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 (pin_ctl_out.pull_high_n == ($past(st.ph) | 8'h08)))
      else $error("pull-high output mismatch");

   AST_PD_SWAP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 (pin_ctl_out.pull_down_n == {$past(st.pd[3:0]), $past(st.pd[7:4])}))
      else $error("pull-down mapping wrong");

   AST_FLAG_STICKY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (int_flags_out[0] && !flag_clear_in[0]) |=> int_flags_out[0])
      else $error("timer flag lost without clear");

   AST_GIE_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (disable_int_instr_in || hw_int_entry_in)
      |=> !timer_watchdog_mode_out[6] ##1 !int_request_out)
      else $error("global enable not masked");

   AST_WDT_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (watchdog_clear_instr_in && st.mode[3] && !mode_write_in) |=> (st.presc == 8'h00))
      else $error("prescaler not cleared");

   AST_READ_PRESC: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (io_ctrl_read_instr_in && io_addr_in == 8'hfa)
      |=> (io_rvalid_out && io_rdata_out == $past(st.presc)))
      else $error("prescaler view wrong");

   AST_SINK: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 (pin_ctl_out.const_sink == ($past(st.sys[2]) && !$past(st.dir[1]))))
      else $error("constant sink mismatch");

   // read data idles at zero so a stale value is never taken for an answer
   AST_RDATA_IDLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !io_rvalid_out |-> (io_rdata_out == 8'h00))
      else $error("read data not zero while idle");

   // enabling alone must raise the global enable bit
   AST_GIE_ON: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ((enable_int_instr_in || return_enable_instr_in)
       && !disable_int_instr_in && !hw_int_entry_in) |=> timer_watchdog_mode_out[ICR_MODE_GIE])
      else $error("global enable not set");

   AST_IRQ_GIE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !timer_watchdog_mode_out[ICR_MODE_GIE] |=> !int_request_out)
      else $error("request raised while masked");

   // bit 6 of the written data is dropped, every other bit must land
   AST_MODE_WRITE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      mode_write_in |=> (((timer_watchdog_mode_out ^ $past(io_wdata_in)) & 8'hbf) == 8'h00))
      else $error("mode write lost");

   AST_TIMER_FREE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (st.mode[ICR_MODE_ASSIGN] && !st.mode[ICR_MODE_SOURCE]) |=> main_timer_tick_out)
      else $error("timer tick missing without prescaler");

   AST_WDT_GATED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !st.sys[ICR_SYS_WDT_EN] |=> !watchdog_reset_out)
      else $error("watchdog reset while disabled");

   // without the configuration enable only the three low sources may request
   AST_WDT_INT_CFG: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (!cfg_wdt_int_enable_in && (int_flags_out & st.imask & 8'h07) == 8'h00)
      |=> !int_request_out)
      else $error("watchdog request without configuration enable");

   // a change on pin 0 alone must not raise the change flag in interrupt mode
   AST_PIN0_NO_CHANGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (st.sys[ICR_SYS_EXT_SEL] && !int_flags_out[ICR_INT_CHANGE]
       && ((port_pins_in ^ st.pin_prev) & st.pce) == 8'h01) |=> !int_flags_out[ICR_INT_CHANGE])
      else $error("pin 0 change flagged while it is the interrupt pin");

   // falling edge selected: a high-to-low step on pin 0 must flag
   AST_EXT_FALL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (st.sys[ICR_SYS_EXT_SEL] && !st.mode[ICR_MODE_EXT_INT_EDGE] && st.pin_prev[0]
       && !port_pins_in[0]) |=> int_flags_out[ICR_INT_EXT])
      else $error("falling edge on interrupt pin not flagged");

   AST_OVF_FLAG: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      timer_overflow_in |=> int_flags_out[ICR_INT_TIMER])
      else $error("overflow flag not set");

   AST_DIR_OE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 (pin_ctl_out.oe_n == $past(st.dir)))
      else $error("output enable does not follow direction");

   // system control outputs follow their register bits one cycle late
   AST_SYS_OUT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 (sys_ctl_out == {$past(st.sys[3]), $past(st.sys[5]),
                           $past(st.sys[7]), $past(st.sys[6])}))
      else $error("system control outputs mismatch");

endmodule

// [icr_pkg.sv]
// constants, register map and carrier types of the i/o control register bank
package icr_pkg;

   // =====================================================================
   // register indices reached by the i/o-control instructions
   localparam logic [7:0] ICR_ADDR_PORT_DIRECTION    = 8'hf6;
   localparam logic [7:0] ICR_ADDR_PIN_CHANGE_ENABLE = 8'hf9;
   localparam logic [7:0] ICR_ADDR_PRESCALER_VIEW    = 8'hfa;
   localparam logic [7:0] ICR_ADDR_PULL_DOWN_CONTROL = 8'hfb;
   localparam logic [7:0] ICR_ADDR_OPEN_DRAIN_CONTROL = 8'hfc;
   localparam logic [7:0] ICR_ADDR_PULL_HIGH_CONTROL = 8'hfd;
   localparam logic [7:0] ICR_ADDR_SYSTEM_CONTROL    = 8'hfe;
   localparam logic [7:0] ICR_ADDR_INTERRUPT_MASK    = 8'hff;

   // =====================================================================
   // values after reset
   localparam logic [7:0] ICR_RST_MODE      = 8'h3f;
   localparam logic [7:0] ICR_RST_DIRECTION = 8'hff;
   localparam logic [7:0] ICR_RST_PCE       = 8'hff;
   localparam logic [7:0] ICR_RST_PRESCALER = 8'hff;
   localparam logic [7:0] ICR_RST_PULL_DOWN = 8'hff;
   localparam logic [7:0] ICR_RST_OPEN_DRAIN = 8'h00;
   localparam logic [7:0] ICR_RST_PULL_HIGH = 8'hff;
   localparam logic [7:0] ICR_RST_SYSCTL    = 8'ha0;
   localparam logic [7:0] ICR_RST_IMASK     = 8'h00;

   // =====================================================================
   // implemented bits of partly used registers
   localparam logic [7:0] ICR_SYSCTL_WMASK = 8'hec;
   localparam logic [7:0] ICR_IMASK_WMASK  = 8'h47;

   // =====================================================================
   // field positions: timer/watchdog mode register
   localparam int ICR_MODE_PS_LSB      = 0;
   localparam int ICR_MODE_ASSIGN      = 3;
   localparam int ICR_MODE_EDGE        = 4;
   localparam int ICR_MODE_SOURCE      = 5;
   localparam int ICR_MODE_GIE         = 6;
   localparam int ICR_MODE_EXT_INT_EDGE = 7;

   // field positions: system control register
   localparam int ICR_SYS_CONST_SINK = 2;
   localparam int ICR_SYS_LOW_POWER  = 3;
   localparam int ICR_SYS_LOW_VOLT   = 5;
   localparam int ICR_SYS_EXT_SEL    = 6;
   localparam int ICR_SYS_WDT_EN     = 7;

   // field positions: interrupt mask and status flags (same layout)
   localparam int ICR_INT_TIMER  = 0;
   localparam int ICR_INT_CHANGE = 1;
   localparam int ICR_INT_EXT    = 2;
   localparam int ICR_INT_WDT    = 6;

   // pin without open-drain or pull-high hardware
   localparam int ICR_PLAIN_PIN = 3;

   // =====================================================================
   // carriers
   typedef struct packed {
      logic [7:0] oe_n;          // low: pin driven by the port
      logic [7:0] pull_down_n;   // low: pull-down on, by pin number
      logic [7:0] open_drain;    // high: open-drain output
      logic [7:0] pull_high_n;   // low: pull-high on
      logic       const_sink;    // constant sink drive on pin 1
   } icr_pin_ctl_t;

   typedef struct packed {
      logic       low_power_reset_enable;
      logic       low_voltage_reset_enable;
      logic       watchdog_enable;
      logic       ext_int_select;
   } icr_sys_ctl_t;

endpackage

// [icr_port_model.sv]
// port pin model standing outside the register bank
`timescale 1ns/1ps
module icr_port_model (
   input  wire logic                  clk_in,
   input  wire icr_pkg::icr_pin_ctl_t pin_ctl_in,
   input  wire logic [7:0]            ext_level_in,
   output logic [7:0]                 pins_out
);
   import icr_pkg::*;
   // =====================================================================
   // pin sampling
   // pin 0 treated like the other pins, output or input
   // a pin driven by the port keeps its level; the outside world is only seen
   // on pins in input mode, one clock late as through a synchroniser
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < 8; i++) begin
         if (pin_ctl_in.oe_n[i]) begin
            pins_out[i] <= ext_level_in[i];
         end
      end
   end
endmodule

// [tb_top.sv]
// self-checking testbench of the i/o control register bank
`timescale 1ns/1ps
module tb_top;
   import icr_pkg::*;
   // =====================================================================
   // stimulus and observation
   logic          sys_clk_in = 1'b0;
   logic          rst_n_in   = 1'b0;
   logic          wr = 1'b0, rd = 1'b0, mwr = 1'b0, ext = 1'b0, cfg = 1'b1;
   logic [7:0]    addr = 8'h00, wdata = 8'h00, ext_pins = 8'h00, pins;
   logic [15:0]   pls = 16'h0000;   // 0 dis,1 hw,2 en,3 ret,4 clr,5 tick,6 ovf
   logic [7:0]    rdata, mode, flags;
   logic          rvalid, tick, wres, req;
   icr_pin_ctl_t  pin_ctl;
   icr_sys_ctl_t  sys_ctl;
   int            bad_count = 0, compares = 0, ticks = 0, wcnt = 0, cycles = 0;
   logic [7:0]    ra [8] = '{8'hf6, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
   logic [7:0]    rv [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'ha0, 8'h00};
   logic [7:0]    rm [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hec, 8'h47};

   always #12.5 sys_clk_in = ~sys_clk_in;

   icr_io_control_register_bank icr_io_control_register_bank_i (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .io_ctrl_write_instr_in(wr), .io_ctrl_read_instr_in(rd),
      .io_addr_in(addr), .io_wdata_in(wdata), .mode_write_in(mwr),
      .disable_int_instr_in(pls[0]), .hw_int_entry_in(pls[1]),
      .enable_int_instr_in(pls[2]), .return_enable_instr_in(pls[3]),
      .watchdog_clear_instr_in(pls[4]), .watchdog_tick_in(pls[5]),
      .cfg_wdt_int_enable_in(cfg), .ext_timer_input_in(ext),
      .port_pins_in(pins), .timer_overflow_in(pls[6]), .flag_clear_in(pls[15:8]),
      .io_rdata_out(rdata), .io_rvalid_out(rvalid), .timer_watchdog_mode_out(mode),
      .main_timer_tick_out(tick), .watchdog_reset_out(wres), .int_flags_out(flags),
      .int_request_out(req), .pin_ctl_out(pin_ctl), .sys_ctl_out(sys_ctl));

   icr_port_model icr_port_model_i (
      .clk_in(sys_clk_in), .pin_ctl_in(pin_ctl), .ext_level_in(ext_pins),
      .pins_out(pins));

   // =====================================================================
   // helpers
   task automatic print_verdict();
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   // one write instruction, strobe high for exactly one rising edge
   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge sys_clk_in);
      wr = 1'b0;
   endtask

   // read answer stands only in the cycle after the strobe, so look there
   task automatic io_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk_in);
      rd = 1'b1;
      addr = a;
      @(negedge sys_clk_in);
      rd = 1'b0;
      chk({rvalid, rdata}, {1'b1, exp});
   endtask

   task automatic md(input logic [7:0] d);
      @(negedge sys_clk_in);
      mwr = 1'b1;
      wdata = d;
      @(negedge sys_clk_in);
      mwr = 1'b0;
   endtask

   task automatic pl(input logic [15:0] v);
      @(negedge sys_clk_in);
      pls = v;
      @(negedge sys_clk_in);
      pls = 16'h0000;
   endtask

   // output pulse counters and the hang guard
   always @(posedge sys_clk_in) begin
      ticks += (tick === 1'b1);
      wcnt += (wres === 1'b1);
      cycles++;
      if (cycles == 10000) begin
         bad_count++;
         print_verdict();
      end
   end

   // =====================================================================
   // scenarios
   initial begin
      cyc(10);
      rst_n_in = 1'b1;
      chk(mode, 8'h3f);
      chk(pin_ctl, {8'hff, 8'hff, 8'h00, 8'hff, 1'b0});
      for (int i = 0; i < 8; i++) io_rd(ra[i], rv[i]);
      // write all ones then all zeros; the count view must ignore both
      for (int i = 0; i < 8; i++) begin
         io_wr(ra[i], 8'hff);
         io_rd(ra[i], rm[i]);
         io_wr(ra[i], 8'h00);
         io_rd(ra[i], {8{i == 2}});
      end
      io_rd(8'hf0, 8'h00);
      io_wr(8'hf6, 8'h5a);
      io_wr(8'hfb, 8'hf0);
      io_wr(8'hfc, 8'hff);
      io_wr(8'hfd, 8'h00);
      io_wr(8'hfe, 8'h04);
      cyc(2);
      chk(pin_ctl, {8'h5a, 8'h0f, 8'hf7, 8'h08, 1'b0});
      io_wr(8'hf6, 8'h58);
      cyc(2);
      chk(pin_ctl, {8'h58, 8'h0f, 8'hf7, 8'h08, 1'b1});
      io_wr(8'hfe, 8'h28);
      cyc(2);
      chk(sys_ctl, 4'b1100);
      io_wr(8'hfe, 8'hc0);
      cyc(2);
      chk(sys_ctl, 4'b0011);
      // global enable: masking wins when both come together
      md(8'h40);
      chk(mode, 8'h00);
      pl(16'h0004);
      chk(mode, 8'h40);
      pl(16'h0005);
      chk(mode, 8'h00);
      pl(16'h0008);
      chk(mode, 8'h40);
      pl(16'h0002);
      chk(mode, 8'h00);
      // internal clock: two ticks in two full ratio periods
      for (int p = 0; p < 8; p++) begin
         md({5'h00, p[2:0]});
         cyc(2);
         ticks = 0;
         cyc(4 << p);
         chk(ticks, 2);
      end
      md(8'h28);
      md(8'h20);
      repeat (3) begin
         ext = 1'b1;
         cyc(2);
         ext = 1'b0;
         cyc(2);
      end
      io_rd(8'hfa, 8'h03);
      md(8'h38);
      md(8'h30);
      repeat (3) begin
         ext = 1'b1;
         cyc(2);
         ext = 1'b0;
         cyc(2);
      end
      io_rd(8'hfa, 8'h03);
      // prescaler on the watchdog: timer ticks every cycle
      io_wr(8'hfe, 8'h80);
      md(8'h0a);
      cyc(2);
      ticks = 0;
      cyc(10);
      chk(ticks, 10);
      pl(16'h0010);
      wcnt = 0;
      repeat (3) pl(16'h0020);
      cyc(2);
      chk(flags, 8'h00);
      pl(16'h0020);
      cyc(1);
      chk(flags, 8'h40);
      repeat (4) pl(16'h0020);
      cyc(2);
      chk(wcnt, 2);
      io_wr(8'hff, 8'h40);
      pl(16'h0004);
      cfg = 1'b0;
      cyc(3);
      chk(req, 1'b0);
      cfg = 1'b1;
      cyc(3);
      chk(req, 1'b1);
      pl(16'hff00);
      cyc(2);
      chk({flags, req}, 9'h000);
      io_wr(8'hff, 8'h01);
      pl(16'h0040);
      cyc(5);
      chk({flags, req}, {8'h01, 1'b1});
      io_wr(8'hff, 8'h00);
      cyc(2);
      chk(req, 1'b0);
      pl(16'hff00);
      // pin change on a disarmed pin, then on an armed one
      io_wr(8'hf6, 8'hff);
      io_wr(8'hf9, 8'h04);
      io_wr(8'hfe, 8'h00);
      cyc(2);
      ext_pins = 8'h02;
      cyc(4);
      chk(flags, 8'h00);
      ext_pins = 8'h06;
      cyc(4);
      chk(flags, 8'h02);
      pl(16'hff00);
      // pin 0 as interrupt input: edge flag only, no change flag
      io_wr(8'hf9, 8'hff);
      io_wr(8'hfe, 8'h40);
      md(8'h80);
      ext_pins = 8'h07;
      cyc(4);
      chk(flags, 8'h04);
      md(8'h00);
      pl(16'hff00);
      ext_pins = 8'h06;
      cyc(4);
      chk(flags, 8'h04);
      pl(16'hff00);
      ext_pins = 8'h07;
      cyc(4);
      chk(flags, 8'h00);
      // watchdog left unassigned: an enabled tick resets and interrupts at once
      io_wr(8'hfe, 8'h00);
      pl(16'hff20);
      wcnt = 0;
      io_wr(8'hfe, 8'h80);
      pl(16'h0020);
      cyc(1);
      chk({flags, wcnt[7:0]}, 16'h4001);
      print_verdict();
   end
endmodule
